// ===== verilog/sleep_id_pkg.sv
/*
 * constants for the sleep, wake, identification and one-time-area
 * command decoder of a serial flash.
 * assumes a single 125 MHz system clock.
 */
package sleep_id_pkg;

    // ------------------------------------------------------------
    // opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] DEEP_SLEEP_CMD     = 8'hB9;
    localparam logic [7:0] WAKE_AND_IDENT_CMD = 8'hAB;
    localparam logic [7:0] MAKER_DEV_ID_CMD   = 8'h90;
    localparam logic [7:0] STANDARD_IDENT_CMD = 8'h9F;
    localparam logic [7:0] OTP_ENTER_CMD      = 8'h3A;
    localparam logic [7:0] WRITE_DISABLE_CMD  = 8'h04;
    localparam logic [7:0] STATUS_WRITE_CMD   = 8'h01;
    localparam logic [7:0] STATUS_READ_CMD    = 8'h05;

    // ------------------------------------------------------------
    // identity (values arbitrary) and mapping
    // ------------------------------------------------------------
    localparam logic [7:0]  MAKER_CODE_DEF = 8'h5A; // arbitrary value
    localparam logic [7:0]  DEVICE_ID_DEF  = 8'h10; // arbitrary value
    localparam logic [7:0]  MEM_TYPE_DEF   = 8'h31; // arbitrary value
    localparam logic [7:0]  CAPACITY_DEF   = 8'h11; // arbitrary value
    localparam logic [23:0] OTP_BASE       = 24'h01F000;
    localparam logic [23:0] OTP_LAST       = 24'h01F0FF;
    localparam logic [23:0] ADDR_ID_SWAP   = 24'h000001;
    localparam logic [2:0]  PROTECT_CLEAR  = 3'h0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ          = 125;
    localparam int SLEEP_ENTRY_NS   = 3000;
    localparam int WAKE_NS          = 3000;
    localparam int WAKE_IDENT_NS    = 1800;
    localparam int HOLDOFF_US       = 1000; // least holdoff, 1 ms
    localparam int SLEEP_ENTRY_CYC  = (SLEEP_ENTRY_NS * CLK_MHZ + 999) / 1000;
    localparam int WAKE_CYC         = (WAKE_NS * CLK_MHZ + 999) / 1000;
    localparam int WAKE_IDENT_CYC   = (WAKE_IDENT_NS * CLK_MHZ + 999) / 1000;
    localparam int HOLDOFF_CYC      = HOLDOFF_US * CLK_MHZ;
    localparam int TIMER_W          = 18;

endpackage

// ===== verilog/flash_sleep_id_otp.sv
/*
 * command decoder for deep sleep, wake, the three identification reads
 * and one-time-area mode of a serial flash.
 * assumes serial pins already sampled into the clk domain (synchronous);
 * the array engine reports its cycle on wip and takes the gate outputs.
 */
// How it works
// - sleep opcode executes only if chip select rises right after bit 8.
// - after that rise, wait sleep-entry delay, then enter deep sleep.
// - in deep sleep every opcode except wake is ignored.
// - sleep opcode during a running write cycle is rejected.
// - plain deselect gives standby only; sleep needs its own opcode.
// - reset (power-on) always comes up in standby.
// - wake-only: opcode then rise; if asleep, busy for the wake delay.
// - wake plus three dummies streams the device id, msb first, repeating.
// - rise after wake: instant if awake, else wake-ident delay.
// - wake works awake too; not decoded during erase/program/status write.
// - 90h with zero address gives maker code then device id.
// - address one swaps: device id first, then maker code.
// - 9Fh streams maker, memory type, capacity; stops on deselect.
// - 9Fh not decoded during erase or program.
// - otp entry maps 256-byte sector onto 01F000h-01F0FFh.
// - in otp mode protect bit reads as seal; seal blocks program/erase.
// - status write in otp mode drops data and sets the seal.
// - otp program/erase only with seal clear and protect level 000.
// - other sectors readable; program/erase only while seal clear.
// - write-disable opcode leaves otp mode.
// - writes refused until the power-up holdoff has passed.
`timescale 1ns/100ps
module flash_sleep_id_otp #(
    parameter int SLEEP_ENTRY  = sleep_id_pkg::SLEEP_ENTRY_CYC,
    parameter int WAKE         = sleep_id_pkg::WAKE_CYC,
    parameter int WAKE_IDENT   = sleep_id_pkg::WAKE_IDENT_CYC,
    parameter int HOLDOFF      = sleep_id_pkg::HOLDOFF_CYC,
    parameter logic [7:0] MAKER_CODE = sleep_id_pkg::MAKER_CODE_DEF,
    parameter logic [7:0] DEVICE_ID  = sleep_id_pkg::DEVICE_ID_DEF
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // serial pins, sampled
    input  wire logic        chip_sel_n,
    input  wire logic        serial_clk,
    input  wire logic        serial_in,
    // serial out with enable, low while driving
    output logic             serial_out,
    output logic             serial_out_oe_n,
    // array engine status
    input  wire logic        wip,
    input  wire logic        wip_is_status_write,
    input  wire logic        status_protect_bit,
    input  wire logic [2:0]  protect_level_field,
    input  wire logic [23:0] array_addr,
    // block state
    output logic             deep_sleep,
    output logic             busy,
    output logic             otp_mode,
    output logic             otp_seal,
    output logic             otp_select,
    output logic             write_allowed,
    output logic             cmd_ignored,
    output logic             status_protect_view
);
    import sleep_id_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_OPCODE = 3'b001,
        ST_ADDR   = 3'b010,
        ST_SHIFT  = 3'b011,
        ST_DONE   = 3'b100,
        ST_SKIP   = 3'b101
    } frame_e;

    typedef enum logic [1:0] {
        PW_AWAKE   = 2'b00,
        PW_ENTER   = 2'b01,
        PW_ASLEEP  = 2'b10,
        PW_WAKING  = 2'b11
    } power_e;

    typedef struct packed {
        frame_e              frame;
        power_e              power;
        logic [7:0]          opcode;
        logic [23:0]         addr;
        logic [5:0]          bits;
        logic [23:0]         out_sr;
        logic [4:0]          out_cnt;
        logic [TIMER_W-1:0]  timer;
        logic [TIMER_W-1:0]  holdoff;
        logic                sck_d;
        logic                cs_d;
        logic                so;
        logic                so_oe_n;
        logic                otp;
        logic                seal;
        logic                ign;
    } state_s;

    state_s cur;
    state_s nxt;

    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic cs_fall;
    logic erase_prog;

    assign sck_rise   = serial_clk & ~cur.sck_d;
    assign sck_fall   = ~serial_clk & cur.sck_d;
    assign cs_rise    = chip_sel_n & ~cur.cs_d;
    assign cs_fall    = ~chip_sel_n & cur.cs_d;
    assign erase_prog = wip & ~wip_is_status_write;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    // reply words, maker/device order picked by the address
    function automatic logic [23:0] reply(input logic [7:0]  op,
                                          input logic [23:0] a);
        logic [23:0] r;
        r = '0;
        if (op == WAKE_AND_IDENT_CMD) begin
            r = {DEVICE_ID, DEVICE_ID, DEVICE_ID};
        end else if (op == MAKER_DEV_ID_CMD) begin
            if (a == ADDR_ID_SWAP) begin
                r = {DEVICE_ID, MAKER_CODE, DEVICE_ID};
            end else begin
                r = {MAKER_CODE, DEVICE_ID, MAKER_CODE};
            end
        end else if (op == STANDARD_IDENT_CMD) begin
            r = {MAKER_CODE, MEM_TYPE_DEF, CAPACITY_DEF};
        end
        return r;
    endfunction

    always_comb begin
        nxt       = cur;
        nxt.sck_d = serial_clk;
        nxt.cs_d  = chip_sel_n;
        nxt.ign   = 1'b0;
        // power-up holdoff counts down once
        if (cur.holdoff != '0) begin
            nxt.holdoff = cur.holdoff - 1'b1;
        end
        // delay timer for sleep entry and wake
        if (cur.timer != '0) begin
            nxt.timer = cur.timer - 1'b1;
        end else if (cur.power == PW_ENTER) begin
            nxt.power = PW_ASLEEP;
        end else if (cur.power == PW_WAKING) begin
            nxt.power = PW_AWAKE;
        end

        unique case (cur.frame)
            ST_IDLE: begin
                if (cs_fall) begin
                    nxt.frame = ST_OPCODE;
                    nxt.bits  = '0;
                end
            end
            ST_OPCODE: begin
                if (sck_rise) begin
                    nxt.opcode = {cur.opcode[6:0], serial_in};
                    nxt.bits   = cur.bits + 1'b1;
                    if (cur.bits == 6'd7) begin
                        nxt.bits  = '0;
                        nxt.frame = ST_DONE;
                        nxt.addr  = '0;
                        // asleep: only wake passes; entering or waking with the timer running: none pass
                        if ((cur.power != PW_AWAKE &&
                             {cur.opcode[6:0], serial_in}
                             != WAKE_AND_IDENT_CMD) ||
                            cur.timer != '0 && cur.power != PW_AWAKE) begin
                            nxt.frame = ST_SKIP;
                            nxt.ign   = 1'b1;
                        end else if (wip &&
                            ({cur.opcode[6:0], serial_in} ==
                             WAKE_AND_IDENT_CMD ||
                             {cur.opcode[6:0], serial_in} ==
                             DEEP_SLEEP_CMD)) begin
                            nxt.frame = ST_SKIP;
                            nxt.ign   = 1'b1;
                        end else if (erase_prog &&
                            {cur.opcode[6:0], serial_in} ==
                            STANDARD_IDENT_CMD) begin
                            nxt.frame = ST_SKIP;
                            nxt.ign   = 1'b1;
                        end else if ({cur.opcode[6:0], serial_in} ==
                                     STANDARD_IDENT_CMD) begin
                            nxt.frame   = ST_SHIFT;
                            nxt.out_sr  = reply(STANDARD_IDENT_CMD, '0);
                            nxt.out_cnt = '0;
                        end else if ({cur.opcode[6:0], serial_in} ==
                                     WAKE_AND_IDENT_CMD ||
                                     {cur.opcode[6:0], serial_in} ==
                                     MAKER_DEV_ID_CMD) begin
                            nxt.frame = ST_ADDR; // dummies or address
                        end
                    end
                end
            end
            ST_ADDR: begin
                if (sck_rise) begin
                    nxt.addr = {cur.addr[22:0], serial_in};
                    nxt.bits = cur.bits + 1'b1;
                    if (cur.bits == 6'd23) begin
                        nxt.frame   = ST_SHIFT;
                        nxt.out_sr  = reply(cur.opcode,
                                            {cur.addr[22:0], serial_in});
                        nxt.out_cnt = '0;
                    end
                end
            end
            ST_SHIFT: begin
                // falling edges, msb first; wrap to repeat the pattern
                if (sck_fall) begin
                    nxt.so      = cur.out_sr[23];
                    nxt.so_oe_n = 1'b0;
                    nxt.out_sr  = {cur.out_sr[22:0], cur.out_sr[23]};
                    nxt.out_cnt = cur.out_cnt + 1'b1;
                    if (cur.out_cnt == 5'd23 || (cur.out_cnt == 5'd15 &&
                        cur.opcode == MAKER_DEV_ID_CMD)) begin
                        nxt.out_cnt = '0;
                        nxt.out_sr  = reply(cur.opcode, cur.addr);
                    end
                end
            end
            ST_DONE: begin
                // any further clock means the rise was not right after bit 8
                if (sck_rise) begin
                    nxt.frame = ST_SKIP;
                end
            end
            ST_SKIP: begin
            end
            default: begin
                nxt.frame = ST_IDLE;
            end
        endcase

        // deselect ends every frame; plain deselect is standby only, never sleep
        if (cs_rise) begin
            nxt.frame   = ST_IDLE;
            nxt.so_oe_n = 1'b1;
            // wake alone sits in the address state with no bits taken
            if (cur.frame == ST_DONE ||
                (cur.frame == ST_ADDR && cur.bits == '0)) begin
                if (cur.opcode == DEEP_SLEEP_CMD) begin
                    nxt.power = PW_ENTER;
                    nxt.timer = TIMER_W'(SLEEP_ENTRY);
                end else if (cur.opcode == WAKE_AND_IDENT_CMD &&
                             cur.power == PW_ASLEEP) begin
                    nxt.power = PW_WAKING;
                    nxt.timer = TIMER_W'(WAKE);
                end else if (cur.opcode == OTP_ENTER_CMD) begin
                    nxt.otp = 1'b1;
                end else if (cur.opcode == WRITE_DISABLE_CMD) begin
                    nxt.otp = 1'b0;
                end
            end else if (cur.frame == ST_SHIFT || cur.frame == ST_ADDR) begin
                if (cur.opcode == WAKE_AND_IDENT_CMD &&
                    cur.power == PW_ASLEEP) begin
                    nxt.power = PW_WAKING;
                    nxt.timer = TIMER_W'(WAKE_IDENT);
                end
            end
            // seal set by status write in otp mode, data dropped
            // the data byte leaves the frame in skip; awake at deselect keeps refusals out unless the wake delay ended mid-frame
            if (cur.otp && cur.opcode == STATUS_WRITE_CMD &&
                cur.power == PW_AWAKE &&
                (cur.frame == ST_SKIP || cur.frame == ST_DONE)) begin
                nxt.seal = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // reset stands for power-on: awake, standby, otp mode off
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cur         <= '0;
            cur.sck_d   <= 1'b0;
            cur.cs_d    <= 1'b1;
            cur.so_oe_n <= 1'b1;
            cur.holdoff <= TIMER_W'(HOLDOFF);
        end else begin
            cur <= nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs, each from a flip-flop
    // ------------------------------------------------------------
    logic [7:0] gate_q;
    logic       in_otp_range;

    assign in_otp_range = array_addr >= OTP_BASE && array_addr <= OTP_LAST;

    // gating for the array engine, registered one cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            gate_q <= 8'h00;
        end else begin
            gate_q[0] <= cur.power != PW_AWAKE;
            gate_q[1] <= cur.power != PW_AWAKE || cur.timer != '0;
            gate_q[2] <= cur.otp;
            gate_q[3] <= cur.seal;
            gate_q[4] <= cur.otp && in_otp_range;
            // writes need awake, holdoff done, and in otp mode no seal
            gate_q[5] <= cur.power == PW_AWAKE && cur.holdoff == '0 &&
                         !(cur.otp && cur.seal) &&
                         !(cur.otp && in_otp_range &&
                           protect_level_field != PROTECT_CLEAR);
            gate_q[6] <= cur.ign;
            gate_q[7] <= cur.otp ? cur.seal : status_protect_bit;
        end
    end

    assign deep_sleep          = gate_q[0];
    assign busy                = gate_q[1];
    assign otp_mode            = gate_q[2];
    assign otp_seal            = gate_q[3];
    assign otp_select          = gate_q[4];
    assign write_allowed       = gate_q[5];
    assign cmd_ignored         = gate_q[6];
    assign status_protect_view = gate_q[7];
    assign serial_out          = cur.so;
    assign serial_out_oe_n     = cur.so_oe_n;

endmodule

// ===== verif/flash_sleep_id_otp_properties.sv
/*
 * port-level checks on the sleep, ident and otp command decoder.
 * assumes one clk domain with sys_rst async high; bound at the foot.
 */
`timescale 1ns/100ps
module flash_sleep_id_otp_properties #(
    parameter int HOLDOFF = 50
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic chip_sel_n,
    input wire logic serial_out_oe_n,
    input wire logic status_protect_bit,
    input wire logic deep_sleep,
    input wire logic busy,
    input wire logic otp_mode,
    input wire logic otp_seal,
    input wire logic otp_select,
    input wire logic write_allowed,
    input wire logic cmd_ignored,
    input wire logic status_protect_view
);
    // ------------------------------------------------------------
    // helper count and clocking
    // ------------------------------------------------------------
    int since_rst;

    // cycles since release, saturating so it never wraps
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            since_rst <= 0;
        else if (since_rst < HOLDOFF)
            since_rst <= since_rst + 1;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    reset_state_a: assert property (
        $fell(sys_rst) |-> !deep_sleep && !busy && !otp_mode
        && serial_out_oe_n) else $error("not idle after reset");
    write_holdoff_a: assert property (
        write_allowed |-> since_rst >= HOLDOFF - 1)
        else $error("write allowed inside holdoff");
    sleep_entry_a: assert property (
        $rose(deep_sleep) |-> $past(chip_sel_n) && $past(chip_sel_n, 2))
        else $error("sleep entered inside a frame");
    asleep_quiet_a: assert property (
        deep_sleep |-> busy && !write_allowed)
        else $error("sleep not busy or writable");
    oe_idle_a: assert property (
        chip_sel_n [*3] |-> serial_out_oe_n)
        else $error("output driven while deselected");
    refuse_pulse_a: assert property (
        cmd_ignored |=> !cmd_ignored) else $error("refusal not a pulse");
    seal_hold_a: assert property (
        otp_seal |=> otp_seal) else $error("seal cleared");
    seal_block_a: assert property (
        otp_mode && $past(otp_mode) && otp_seal && $past(otp_seal)
        |-> !write_allowed) else $error("write allowed when sealed");
    otp_select_a: assert property (
        otp_select |-> otp_mode || $past(otp_mode))
        else $error("otp sector mapped outside otp mode");
    protect_view_a: assert property (
        !otp_mode && !$past(otp_mode) && !$past(sys_rst)
        && !$past(sys_rst, 2)
        && status_protect_bit == $past(status_protect_bit)
        |-> status_protect_view == status_protect_bit)
        else $error("protect view wrong outside otp");
endmodule

bind flash_sleep_id_otp flash_sleep_id_otp_properties #(
    .HOLDOFF(HOLDOFF)
) i_props (
    .clk(clk), .sys_rst(sys_rst), .chip_sel_n(chip_sel_n),
    .serial_out_oe_n(serial_out_oe_n), .deep_sleep(deep_sleep),
    .status_protect_bit(status_protect_bit), .busy(busy),
    .otp_mode(otp_mode), .otp_seal(otp_seal), .otp_select(otp_select),
    .write_allowed(write_allowed), .cmd_ignored(cmd_ignored),
    .status_protect_view(status_protect_view)
);

// ===== verif/spi_host_model.sv
/*
 * behavioural spi host, mode 0, msb first.
 * assumes the bench calls its tasks at clk rising edges.
 */
`timescale 1ns/100ps
module spi_host_model (
    // clock
    input  wire logic clk,
    // serial pins
    output logic      chip_sel_n,
    output logic      serial_clk,
    output logic      serial_in,
    input  wire logic serial_out
);
    // idle: deselected, clock parked low
    initial begin
        chip_sel_n = 1'b1;
        serial_clk = 1'b0;
        serial_in  = 1'b0;
    end

    // open a frame, select ahead of the first rise
    task automatic sel();
        chip_sel_n <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // one byte; slow phases leave the reply settled before each rise
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            serial_clk <= 1'b0;
            serial_in  <= tx[i];
            repeat (4) @(posedge clk);
            rx[i] = serial_out;
            serial_clk <= 1'b1;
            repeat (3) @(posedge clk);
        end
    endtask

    // close right after the last rise; data line no longer held
    task automatic desel();
        serial_clk <= 1'b0;
        @(posedge clk);
        chip_sel_n <= 1'b1;
        serial_in  <= ~serial_in;
        repeat (2) @(posedge clk);
    endtask
endmodule

// ===== verif/flash_sleep_id_otp_commands_bench.sv
/*
 * self-checking bench for the sleep, ident and otp command decoder.
 * assumes the spi host model and the bound checker; short delays.
 */
`timescale 1ns/100ps
module flash_sleep_id_otp_commands_bench;
    import sleep_id_pkg::*;
    localparam int SLP = 20;
    localparam int WK  = 16;
    localparam int WKI = 12;
    localparam int HO  = 50;
    logic clk, sys_rst, chip_sel_n, serial_clk, serial_in;
    logic serial_out, serial_out_oe_n, deep_sleep, busy, otp_mode;
    logic otp_seal, otp_select, write_allowed, cmd_ignored;
    logic status_protect_view, wip, wip_is_status_write;
    logic status_protect_bit, ign_seen, drv_seen;
    logic [2:0]  protect_level_field;
    logic [23:0] array_addr;
    logic [31:0] got;
    logic [7:0]  r;
    int errors, total_checks;

    flash_sleep_id_otp #(.SLEEP_ENTRY(SLP), .WAKE(WK),
        .WAKE_IDENT(WKI), .HOLDOFF(HO)) i_dut (
        .clk(clk), .sys_rst(sys_rst), .chip_sel_n(chip_sel_n),
        .serial_clk(serial_clk), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
        .wip(wip), .wip_is_status_write(wip_is_status_write),
        .status_protect_bit(status_protect_bit),
        .protect_level_field(protect_level_field),
        .array_addr(array_addr), .deep_sleep(deep_sleep), .busy(busy),
        .otp_mode(otp_mode), .otp_seal(otp_seal), .otp_select(otp_select),
        .write_allowed(write_allowed), .cmd_ignored(cmd_ignored),
        .status_protect_view(status_protect_view));
    spi_host_model i_host (.clk(clk), .chip_sel_n(chip_sel_n),
        .serial_clk(serial_clk), .serial_in(serial_in),
        .serial_out(serial_out));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // sticky flags: refusals are one-cycle pulses, easy to miss
    always @(posedge clk) begin
        if (cmd_ignored === 1'b1) ign_seen <= 1'b1;
        if (serial_out_oe_n === 1'b0) drv_seen <= 1'b1;
    end

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic op_only(input logic [7:0] op);
        i_host.sel();
        i_host.xfer(op, r);
        i_host.desel();
    endtask

    // opcode, na address/dummy bytes (last one given), four reply bytes
    task automatic rd4(input logic [7:0] op, input int na,
                       input logic [7:0] last);
        i_host.sel();
        i_host.xfer(op, r);
        for (int i = 1; i <= na; i++)
            i_host.xfer((i == na) ? last : 8'h00, r);
        for (int i = 0; i < 4; i++) begin
            i_host.xfer(8'h00, r);
            got = {got[23:0], r};
        end
        i_host.desel();
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_power_up();
        chk("sleep at reset", deep_sleep, 1'b0);
        chk("oe_n at reset", serial_out_oe_n, 1'b1);
        chk("early write", write_allowed, 1'b0);
        cyc(HO + 4);
        chk("write after holdoff", write_allowed, 1'b1);
    endtask

    task automatic t_idents();
        rd4(STANDARD_IDENT_CMD, 0, 8'h00);
        chk("std ident", got, {MAKER_CODE_DEF, MEM_TYPE_DEF,
            CAPACITY_DEF, MAKER_CODE_DEF});
        chk("released", serial_out_oe_n, 1'b1);
        for (int s = 0; s < 2; s++) begin
            rd4(MAKER_DEV_ID_CMD, 3, 8'(s));
            chk("maker dev", got, (s == 0) ?
                {2{MAKER_CODE_DEF, DEVICE_ID_DEF}} :
                {2{DEVICE_ID_DEF, MAKER_CODE_DEF}});
        end
        rd4(WAKE_AND_IDENT_CMD, 3, 8'h00);
        chk("dev id awake", got, {4{DEVICE_ID_DEF}});
        chk("no wait awake", busy, 1'b0);
    endtask

    task automatic t_sleep();
        i_host.sel();
        i_host.xfer(DEEP_SLEEP_CMD, r);
        i_host.xfer(8'h00, r);
        i_host.desel();
        cyc(SLP + 4);
        chk("extra clock", deep_sleep, 1'b0);
        op_only(DEEP_SLEEP_CMD);
        cyc(2);
        chk("sleep entered", deep_sleep, 1'b1);
        cyc(SLP + 4);
        ign_seen <= 1'b0;
        drv_seen <= 1'b0;
        rd4(MAKER_DEV_ID_CMD, 3, 8'h00);
        chk("ignored asleep", ign_seen, 1'b1);
        chk("silent asleep", drv_seen, 1'b0);
        op_only(WAKE_AND_IDENT_CMD);
        cyc(WK - 4);
        chk("busy waking", busy, 1'b1);
        cyc(8);
        chk("awake", busy | deep_sleep, 1'b0);
        op_only(DEEP_SLEEP_CMD);
        cyc(SLP + 8);
        rd4(WAKE_AND_IDENT_CMD, 3, 8'h00);
        chk("id from sleep", got, {4{DEVICE_ID_DEF}});
        cyc(WKI - 4);
        chk("busy wake id", busy, 1'b1);
        cyc(8);
        chk("awake after id", busy | deep_sleep, 1'b0);
    endtask

    task automatic t_wip();
        wip <= 1'b1;
        ign_seen <= 1'b0;
        op_only(DEEP_SLEEP_CMD);
        cyc(4);
        chk("sleep in cycle", {ign_seen, deep_sleep}, 2'b10);
        ign_seen <= 1'b0;
        drv_seen <= 1'b0;
        rd4(STANDARD_IDENT_CMD, 0, 8'h00);
        chk("std in cycle", {ign_seen, drv_seen}, 2'b10);
        wip_is_status_write <= 1'b1;
        ign_seen <= 1'b0;
        rd4(WAKE_AND_IDENT_CMD, 3, 8'h00);
        chk("wake in cycle", ign_seen, 1'b1);
        wip <= 1'b0;
        wip_is_status_write <= 1'b0;
    endtask

    task automatic t_otp();
        protect_level_field <= PROTECT_CLEAR;
        array_addr <= OTP_BASE;
        op_only(OTP_ENTER_CMD);
        cyc(3);
        chk("otp entry", {otp_mode, otp_select, write_allowed},
            3'b111);
        array_addr <= OTP_LAST + 24'h1;
        cyc(3);
        chk("past otp", {otp_select, write_allowed}, 2'b01);
        array_addr <= OTP_LAST;
        protect_level_field <= 3'h1;
        cyc(3);
        chk("otp protected", {otp_select, write_allowed}, 2'b10);
        protect_level_field <= PROTECT_CLEAR;
        i_host.sel();
        i_host.xfer(STATUS_WRITE_CMD, r);
        i_host.xfer(8'h00, r);
        i_host.desel();
        cyc(3);
        chk("sealed", {otp_seal, status_protect_view, write_allowed},
            3'b110);
        array_addr <= OTP_BASE - 24'h1;
        cyc(3);
        chk("sealed other", write_allowed, 1'b0);
        op_only(WRITE_DISABLE_CMD);
        status_protect_bit <= 1'b1;
        cyc(3);
        chk("otp left", {otp_mode, otp_select}, 2'b00);
        chk("plain view", status_protect_view, 1'b1);
    endtask

    // ------------------------------------------------------------
    // clock, sequence, watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        sys_rst = 1'b1;
        {wip, wip_is_status_write, status_protect_bit} = 3'b000;
        {ign_seen, drv_seen, got} = '0;
        protect_level_field = PROTECT_CLEAR;
        array_addr = 24'h000000;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_power_up();
        t_idents();
        t_sleep();
        t_wip();
        t_otp();
        complete_run();
    end

    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        complete_run();
    end
endmodule
